/* File: hw/can_filter_pkg.sv */
// Purpose: shared constants and types of the identifier lookup engine
// Assumes: word-addressed register port, lookup RAM of 512 words of 32 bits
// Notes:   boundaries are word indices into the lookup RAM
package can_filter_pkg;

    // lookup RAM geometry
    localparam int RAM_WORDS = 512;                     // words in the lookup RAM
    localparam int RAM_AW    = 9;                       // RAM word address width
    localparam int BND_W     = 10;                      // boundary width, reaches RAM_WORDS
    localparam int ADDR_W    = 11;                      // register port word address width

    // register port map, word addresses
    localparam logic [10:0] A_RAM_TOP = 11'h1FF;        // last RAM word
    localparam logic [10:0] A_MODE    = 11'h200;        // mode: off, bypass, direct store
    localparam logic [10:0] A_BND0    = 11'h201;        // first of five table starts
    localparam logic [10:0] A_EOT     = 11'h206;        // end of tables
    localparam logic [10:0] A_STATUS  = 11'h207;        // bit 0: search busy

    // mode field layout and value after reset
    localparam int         MODE_OFF_BIT = 0;            // filter_off
    localparam int         MODE_BYP_BIT = 1;            // filter_bypass
    localparam int         MODE_DSE_BIT = 2;            // direct_store_enable
    localparam logic [2:0] MODE_RST     = 3'h1;         // off after reset

    // standard halfword entry: ctrl[15:13], disable[12], id[10:0]
    localparam int STD_CTRL_HI = 15;
    localparam int STD_CTRL_LO = 13;
    localparam int STD_DIS_BIT = 12;
    localparam int STD_ID_HI   = 10;
    // extended word entry: ctrl[31:29], id[28:0]
    localparam int EXT_CTRL_HI = 31;
    localparam int EXT_CTRL_LO = 29;
    localparam int EXT_ID_HI   = 28;

    // bits software may touch in standard tables while filtering is active
    localparam logic [31:0] DIS_MASK  = 32'h1000_1000;
    localparam logic [31:0] FULL_MASK = 32'hFFFF_FFFF;

    // table numbers, in search order
    localparam logic [2:0] T_DS  = 3'h0;                // direct-store standard
    localparam logic [2:0] T_SI  = 3'h1;                // individual standard
    localparam logic [2:0] T_SR  = 3'h2;                // standard ranges
    localparam logic [2:0] T_EI  = 3'h3;                // individual extended
    localparam logic [2:0] T_ER  = 3'h4;                // extended range pairs
    localparam logic [2:0] B_EOT = 3'h5;                // slot of end of tables

    // search sequencer states
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_TABLE = 3'b001,
        S_READ  = 3'b010,
        S_CHECK = 3'b011,
        S_DONE  = 3'b100
    } phase_type;

endpackage

/* File: hw/can_lookup_ram.sv */
// Purpose: lookup RAM with a software port and a search read port
// Assumes: one clock, read data registered, bit-masked write
// Notes:   a read of a word written in the same cycle returns the old value
`timescale 1ns/100ps
module can_lookup_ram #(
    parameter int DEPTH = 512,
    parameter int AW    = 9,
    parameter int DW    = 32
) (
    input  wire logic          clock,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [DW-1:0] wr_mask,
    input  wire logic [AW-1:0] a_addr,
    output logic      [DW-1:0] a_data,
    input  wire logic [AW-1:0] b_addr,
    output logic      [DW-1:0] b_data
);

    logic [DW-1:0] mem [DEPTH];                          // table storage

    // masked write, bits outside the mask keep their value
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // both read ports registered
    always_ff @(posedge clock) begin
        a_data <= mem[a_addr];
        b_data <= mem[b_addr];
    end

endmodule

/* File: hw/can_identifier_acceptance_filter.sv */
// Purpose: identifier lookup engine shared by the receive sides of several bus controllers
// Assumes: requests synchronous to clock, one search at a time, register port never stalls
// Notes:   linear scan of each table, one RAM word per two cycles at most
`timescale 1ns/100ps

module can_identifier_acceptance_filter #(
    parameter int NUM_CTRL  = 4,                        // controllers served, 2 or 4
    parameter int CTRL_BASE = 1                         // number of first controller, 0 or 1
) (
    input  wire logic                              clock,
    input  wire logic                              rst,
    input  wire logic [can_filter_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                       wdata,
    input  wire logic                              wr_stb,
    input  wire logic                              rd_stb,
    output logic      [31:0]                       rdata,
    input  wire logic                              req_valid,
    output logic                                   req_ready,
    input  wire logic [1:0]                        req_ctrl,
    input  wire logic                              req_ext,
    input  wire logic [28:0]                       req_id,
    output logic                                   resp_valid,
    output logic                                   resp_accept,
    output logic                                   resp_direct,
    output logic      [9:0]                        resp_index
);
    import can_filter_pkg::*;

    // whole state of the engine
    typedef struct packed {
        phase_type             state;                   // sequencer phase
        logic [2:0]            tbl;                     // table being searched
        logic [BND_W-1:0]      ptr;                     // RAM word under test
        logic                  half;                    // 1: low halfword entry
        logic                  pair;                    // 1: extended range upper word due
        logic [28:0]           lo_id;                   // lower bound of extended pair
        logic [2:0]            lo_ctrl;                 // controller of extended pair
        logic [2:0]            ctrl;                    // latched controller number
        logic                  ext;                     // latched identifier size
        logic [28:0]           id;                      // latched identifier
        logic [9:0]            index;                   // entry count within search, restarted after the direct-store table
        logic                  accept;                  // answer: keep frame
        logic                  direct;                  // answer: hit in direct-store table
        logic [2:0]            mode;                    // off, bypass, direct store
        logic [5:0][BND_W-1:0] bnd;                     // table starts and end of tables
        logic [31:0]           rdata;                   // register read data
        logic                  ram_sel;                 // read strobe of the previous cycle went to RAM
    } filt_state_type;

    filt_state_type s_r;                                // registered state
    filt_state_type s_nxt;                              // next state

    logic [31:0]       ram_a_data;                      // software read data from RAM
    logic [31:0]       ram_b_data;                      // search read data from RAM
    logic              ram_we;                          // RAM write enable
    logic [31:0]       ram_mask;                        // RAM bit write mask
    logic              active;                          // table filtering in force
    logic [BND_W-1:0]  t_start;                         // start of current table
    logic [BND_W-1:0]  t_end;                           // end of current table
    logic              t_empty;                         // current table holds nothing
    logic              last_word;                       // ptr is last word of table
    logic [15:0]       std_ent;                         // standard entry under test
    logic              std_hit;                         // standard entry matches
    logic              rng_hit;                         // standard range matches
    logic              ext_hit;                         // extended entry matches
    logic              erng_hit;                        // extended pair matches
    logic              t_miss;                          // current table exhausted
    logic              hit;                             // frame matched this cycle
    logic [2:0]        bsel;                            // boundary register select
    logic [BND_W-1:0]  wr_word;                         // RAM word being written

    // lookup RAM, software port and search port
    can_lookup_ram #(
        .DEPTH (RAM_WORDS),
        .AW    (RAM_AW),
        .DW    (32)
    ) u_ram (
        .clock   (clock),
        .wr_en   (ram_we),
        .wr_addr (addr[RAM_AW-1:0]),
        .wr_data (wdata),
        .wr_mask (ram_mask),
        .a_addr  (addr[RAM_AW-1:0]),
        .a_data  (ram_a_data),
        .b_addr  (s_r.ptr[RAM_AW-1:0]),
        .b_data  (ram_b_data)
    );

    // decode of the table being searched
    always_comb begin
        active    = !s_r.mode[MODE_OFF_BIT] && !s_r.mode[MODE_BYP_BIT];
        t_start   = s_r.bnd[s_r.tbl];
        t_end     = (s_r.tbl == T_ER) ? s_r.bnd[B_EOT] : s_r.bnd[3'(s_r.tbl + 3'h1)];
        t_empty   = (t_start == t_end) || (t_start == s_r.bnd[B_EOT]);
        last_word = (BND_W'(s_r.ptr + 10'h1) == t_end);
        bsel      = 3'(addr - A_BND0);
        wr_word   = {1'b0, addr[RAM_AW-1:0]};
    end

    // entry comparators on the word returned by the search port
    always_comb begin
        std_ent  = s_r.half ? ram_b_data[15:0] : ram_b_data[31:16];
        // controller, enable and identifier must all agree
        std_hit  = (std_ent[STD_CTRL_HI:STD_CTRL_LO] == s_r.ctrl)
                 && !std_ent[STD_DIS_BIT]
                 && (std_ent[STD_ID_HI:0] == s_r.id[10:0]);
        // range: lower bound high halfword, upper bound low halfword, both inclusive
        rng_hit  = (ram_b_data[16+STD_CTRL_HI:16+STD_CTRL_LO] == s_r.ctrl)
                 && !ram_b_data[16+STD_DIS_BIT] && !ram_b_data[STD_DIS_BIT]
                 && (s_r.id[10:0] >= ram_b_data[16+STD_ID_HI:16])
                 && (s_r.id[10:0] <= ram_b_data[STD_ID_HI:0]);
        ext_hit  = (ram_b_data[EXT_CTRL_HI:EXT_CTRL_LO] == s_r.ctrl)
                 && (ram_b_data[EXT_ID_HI:0] == s_r.id);
        // upper word of a pair against the stored lower word
        erng_hit = (s_r.lo_ctrl == s_r.ctrl)
                 && (ram_b_data[EXT_CTRL_HI:EXT_CTRL_LO] == s_r.ctrl)
                 && (s_r.id >= s_r.lo_id)
                 && (s_r.id <= ram_b_data[EXT_ID_HI:0]);
    end

    // next state: register port, then the search sequencer
    always_comb begin
        s_nxt    = s_r;
        ram_we   = 1'b0;
        ram_mask = FULL_MASK;
        t_miss   = 1'b0;
        hit      = 1'b0;
        s_nxt.ram_sel = 1'b0;

        // register and RAM writes
        if (wr_stb) begin
            if (addr <= A_RAM_TOP) begin
                ram_we = 1'b1;
                if (active) begin
                    // standard tables: only disable bits move, elsewhere nothing
                    if (wr_word >= s_r.bnd[T_DS] && wr_word < s_r.bnd[T_EI]) begin
                        ram_mask = DIS_MASK;
                    end else begin
                        ram_mask = 32'h0000_0000;
                    end
                end
            end else if (addr == A_MODE) begin
                s_nxt.mode = wdata[2:0];
            end else if (addr >= A_BND0 && addr <= A_EOT) begin
                s_nxt.bnd[bsel] = wdata[BND_W-1:0];
            end
        end

        // register and RAM reads, data stands in the next cycle
        if (rd_stb) begin
            s_nxt.rdata = 32'h0000_0000;
            if (addr <= A_RAM_TOP) begin
                s_nxt.ram_sel = 1'b1;
            end else if (addr == A_MODE) begin
                s_nxt.rdata = {29'h0, s_r.mode};
            end else if (addr >= A_BND0 && addr <= A_EOT) begin
                s_nxt.rdata = {22'h0, s_r.bnd[bsel]};
            end else if (addr == A_STATUS) begin
                s_nxt.rdata = {31'h0, (s_r.state != S_IDLE)};
            end
        end

        unique case (s_r.state)
            // wait for a receiver with a complete identifier
            S_IDLE: begin
                if (req_valid) begin
                    s_nxt.ctrl   = 3'(req_ctrl) + 3'(CTRL_BASE);
                    s_nxt.ext    = req_ext;
                    s_nxt.id     = req_ext ? req_id : {18'h0, req_id[10:0]};
                    s_nxt.index  = 10'h000;
                    s_nxt.direct = 1'b0;
                    s_nxt.accept = 1'b0;
                    if (s_r.mode[MODE_BYP_BIT]) begin
                        // bypass keeps every frame of a served controller
                        s_nxt.accept = (32'(req_ctrl) < NUM_CTRL);
                        s_nxt.state  = S_DONE;
                    end else if (s_r.mode[MODE_OFF_BIT]) begin
                        s_nxt.state  = S_DONE;
                    end else if (32'(req_ctrl) >= NUM_CTRL) begin
                        s_nxt.state  = S_DONE;
                    end else begin
                        // extended frames skip the direct-store table
                        if (req_ext) begin
                            s_nxt.tbl = T_EI;
                        end else if (s_r.mode[MODE_DSE_BIT]) begin
                            s_nxt.tbl = T_DS;
                        end else begin
                            s_nxt.tbl = T_SI;
                        end
                        s_nxt.state = S_TABLE;
                    end
                end
            end
            // open a table or skip it when empty
            S_TABLE: begin
                if (t_empty) begin
                    t_miss = 1'b1;
                end else begin
                    s_nxt.ptr   = t_start;
                    s_nxt.half  = 1'b0;
                    s_nxt.pair  = 1'b0;
                    s_nxt.state = S_READ;
                end
            end
            // address presented, data arrives next cycle
            S_READ: begin
                s_nxt.state = S_CHECK;
            end
            // test the entry or entries in the fetched word
            S_CHECK: begin
                if (s_r.tbl == T_DS || s_r.tbl == T_SI) begin
                    if (std_hit) begin
                        hit = 1'b1;
                    end else if (!s_r.half) begin
                        s_nxt.half  = 1'b1;
                        s_nxt.index = 10'(s_r.index + 10'h1);
                    end else begin
                        s_nxt.index = 10'(s_r.index + 10'h1);
                        s_nxt.ptr   = BND_W'(s_r.ptr + 10'h1);
                        s_nxt.half  = 1'b0;
                        if (last_word) t_miss = 1'b1;
                        else s_nxt.state = S_READ;
                    end
                end else if (s_r.tbl == T_SR || s_r.tbl == T_EI) begin
                    if ((s_r.tbl == T_SR) ? rng_hit : ext_hit) begin
                        hit = 1'b1;
                    end else begin
                        s_nxt.index = 10'(s_r.index + 10'h1);
                        s_nxt.ptr   = BND_W'(s_r.ptr + 10'h1);
                        if (last_word) t_miss = 1'b1;
                        else s_nxt.state = S_READ;
                    end
                end else begin
                    // extended range: lower word first, then upper word
                    if (!s_r.pair) begin
                        s_nxt.lo_id   = ram_b_data[EXT_ID_HI:0];
                        s_nxt.lo_ctrl = ram_b_data[EXT_CTRL_HI:EXT_CTRL_LO];
                        s_nxt.pair    = 1'b1;
                        s_nxt.ptr     = BND_W'(s_r.ptr + 10'h1);
                        if (last_word) t_miss = 1'b1;
                        else s_nxt.state = S_READ;
                    end else if (erng_hit) begin
                        hit = 1'b1;
                    end else begin
                        s_nxt.pair  = 1'b0;
                        s_nxt.index = 10'(s_r.index + 10'h1);
                        s_nxt.ptr   = BND_W'(s_r.ptr + 10'h1);
                        if (last_word) t_miss = 1'b1;
                        else s_nxt.state = S_READ;
                    end
                end
            end
            // answer stands for one cycle
            S_DONE: begin
                s_nxt.state = S_IDLE;
            end
        endcase

        // a match ends the search with keep
        if (hit) begin
            s_nxt.accept = 1'b1;
            s_nxt.direct = (s_r.tbl == T_DS);
            s_nxt.state  = S_DONE;
        end

        // table exhausted: move to the next table of the same size, discard after the last one
        if (t_miss) begin
            unique case (s_r.tbl)
                T_DS: begin
                    s_nxt.tbl   = T_SI;
                    s_nxt.index = 10'h000;
                    s_nxt.state = S_TABLE;
                end
                T_SI: begin
                    s_nxt.tbl   = T_SR;
                    s_nxt.state = S_TABLE;
                end
                T_EI: begin
                    s_nxt.tbl   = T_ER;
                    s_nxt.state = S_TABLE;
                end
                default: begin
                    s_nxt.accept = 1'b0;
                    s_nxt.state  = S_DONE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r      <= '0;
            s_r.mode <= MODE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign req_ready   = (s_r.state == S_IDLE);
    assign resp_valid  = (s_r.state == S_DONE);
    assign resp_accept = s_r.accept;
    assign resp_direct = s_r.direct;
    assign resp_index  = s_r.index;
    assign rdata       = s_r.ram_sel ? ram_a_data : s_r.rdata;

    // checks
    a_bypass_accept: assert property (@(posedge clock) disable iff (rst)
        (req_ready && req_valid && s_r.mode[MODE_BYP_BIT] && req_ctrl == 2'h0)
        |=> (resp_valid && resp_accept)) else $error("bypass frame not accepted next cycle");
    a_off_discard: assert property (@(posedge clock) disable iff (rst)
        (req_ready && req_valid && !s_r.mode[MODE_BYP_BIT] && s_r.mode[MODE_OFF_BIT])
        |=> (resp_valid && !resp_accept)) else $error("off filter did not discard");
    a_ext_no_direct: assert property (@(posedge clock) disable iff (rst)
        (resp_valid && s_r.ext) |-> !resp_direct) else $error("extended frame hit direct store");
    a_ds_first: assert property (@(posedge clock) disable iff (rst)
        (req_ready && req_valid && active && !req_ext && s_r.mode[MODE_DSE_BIT] && req_ctrl == 2'h0)
        |=> (s_r.state == S_TABLE && s_r.tbl == T_DS)) else $error("direct-store table not first");
    a_ext_start: assert property (@(posedge clock) disable iff (rst)
        (req_ready && req_valid && active && req_ext && req_ctrl == 2'h0)
        |=> (s_r.tbl == T_EI)) else $error("extended search not on extended table");
    a_empty_skip: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == S_TABLE && t_empty) |=> (s_r.state != S_READ)) else $error("empty table read");
    a_active_mask: assert property (@(posedge clock) disable iff (rst)
        (ram_we && active) |-> (ram_mask == DIS_MASK || ram_mask == 32'h0000_0000))
        else $error("active filter write not masked");
    a_pair_read: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == S_CHECK && s_r.tbl == T_ER && !s_r.pair && !last_word)
        |=> (s_r.state == S_READ && s_r.pair) ##1 (s_r.state == S_CHECK))
        else $error("range pair upper word not fetched");
    a_resp_pulse: assert property (@(posedge clock) disable iff (rst)
        resp_valid |=> (!resp_valid && req_ready)) else $error("answer longer than one cycle");
    a_miss_order: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == S_TABLE && s_r.tbl == T_SI && t_empty) |=> (s_r.tbl == T_SR))
        else $error("range table not searched after individual");

endmodule

/* File: dv/rx_partner.sv */
// Purpose: receive side of a bus controller offering identifiers
// Assumes: go pulses one cycle while no request is pending
// Notes:   idle identifier lines toggle outside reset, never keep an old value there
`timescale 1ns/100ps
module rx_partner (
    input  wire logic        clock, rst, go, ready, e,
    input  wire logic [1:0]  c,
    input  wire logic [28:0] i,
    output logic             valid = 1'b0, ext = 1'b0,
    output logic [1:0]       ctrl = 2'h0,
    output logic [28:0]      id = 29'h0
);
    // request and fields stand until the filter takes them
    always_ff @(posedge clock) begin
        if (go) begin
            valid <= 1'b1;
            {ctrl, ext, id} <= {c, e, i};
        end else if (rst || (valid && ready)) valid <= 1'b0;
        else if (!valid) id <= ~id;
    end
endmodule

/* File: dv/tb_can_identifier_acceptance_filter.sv */
// Purpose: scenario bench of the identifier lookup engine
// Assumes: tables loaded while the filter is off
// Notes:   controller field in the tables is port number plus one
`timescale 1ns/100ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin err_total++; \
    $display("wrong value at %0t: %0h vs %0h", $time, g, x); end end
module tb_can_identifier_acceptance_filter;
    import can_filter_pkg::*;
    logic clock = 0, rst = 1, wr_stb = 0, rd_stb = 0, go = 0, e = 0;
    logic req_valid, req_ready, req_ext, resp_valid, resp_accept, resp_direct;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] c = '0, req_ctrl;
    logic [28:0] i = '0, req_id;
    logic [9:0] resp_index;
    int err_total = 0, num_checks = 0;
    can_identifier_acceptance_filter dut (.*);
    rx_partner rx (.clock, .rst, .go, .ready(req_ready), .e, .c, .i,
        .valid(req_valid), .ext(req_ext), .ctrl(req_ctrl), .id(req_id));
    initial forever #10 clock = ~clock;
    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        @(posedge clock); wr_stb <= 1; addr <= a; wdata <= d;
        @(posedge clock); wr_stb <= 0;
    endtask
    // read data judged in the cycle after the strobe
    task automatic rd(input logic [10:0] a, input logic [31:0] x);
        @(posedge clock); rd_stb <= 1; addr <= a;
        @(posedge clock); rd_stb <= 0; #1;
        `CHK(rdata, x)
    endtask
    // x is {accept, direct, index}; a discard judges accept only
    task automatic fr(input logic [1:0] cc, input logic ee, input logic [28:0] ii, input logic [11:0] x);
        int n = 0;
        @(posedge clock); go <= 1; c <= cc; e <= ee; i <= ii;
        @(posedge clock); go <= 0;
        do begin @(posedge clock); #1; n++; end while (resp_valid !== 1'b1 && n < 300);
        if (x[11]) `CHK({resp_valid, req_ready, resp_accept, resp_direct, resp_index}, {2'b10, x})
        else `CHK({resp_valid, req_ready, resp_accept}, 3'b100)
    endtask
    task automatic t_mode;
        rd(A_MODE, {29'h0, MODE_RST});
        rd(A_STATUS, 32'h0);
        `CHK({req_ready, resp_valid, resp_accept, resp_direct, resp_index}, 14'h2000)
        rd(11'h208, 32'h0);
        fr(2'h0, 1'b0, 29'h30, 12'h000);
        wr(A_MODE, 32'h2);
        fr(2'h3, 1'b1, 29'h1ABCDEF, 12'h800);
        fr(2'h0, 1'b0, 29'h7FF, 12'h800);
        $display("test mode done");
    endtask
    task automatic t_load;
        wr(A_MODE, 32'h1);
        wr(A_RAM_TOP, 32'hA5A5_5A5A);
        rd(A_RAM_TOP, 32'hA5A5_5A5A);
        wr(11'h0, 32'h2010_2020);
        wr(11'h1, 32'h2030_3040);
        wr(11'h2, 32'h2100_21FF);
        wr(11'h3, 32'h2123_4567);
        wr(11'h4, 32'h2200_0000);
        wr(11'h5, 32'h22FF_FFFF);
        for (int k = 0; k < 6; k++) wr(A_BND0 + 11'(k), 32'(k + (k == 5)));
        rd(A_EOT, 32'h6);
        wr(A_MODE, 32'h4);
        fr(2'h0, 1'b0, 29'h20, 12'hC01);
        fr(2'h0, 1'b0, 29'h30, 12'h800);
        fr(2'h0, 1'b0, 29'h40, 12'h000);
        fr(2'h0, 1'b0, 29'h150, 12'h802);
        fr(2'h1, 1'b0, 29'h30, 12'h000);
        fr(2'h0, 1'b1, 29'h1234567, 12'h800);
        fr(2'h0, 1'b1, 29'h10, 12'h000);
        fr(2'h0, 1'b1, 29'h2FFFFFF, 12'h801);
        fr(2'h0, 1'b1, 29'h3000000, 12'h000);
        $display("test search done");
    endtask
    task automatic t_dis;
        wr(11'h2, 32'hFFFF_FFFF);
        rd(11'h2, 32'h3100_31FF);
        fr(2'h0, 1'b0, 29'h150, 12'h000);
        wr(11'h2, 32'h0);
        rd(11'h2, 32'h2100_21FF);
        fr(2'h0, 1'b0, 29'h150, 12'h802);
        wr(11'h3, 32'h0);
        rd(11'h3, 32'h2123_4567);
        wr(A_BND0 + 11'h1, 32'h0);
        fr(2'h0, 1'b0, 29'h20, 12'h801);
        // direct store off and individual table emptied: search falls to ranges
        wr(A_MODE, 32'h0);
        wr(A_BND0 + 11'h2, 32'h0);
        fr(2'h0, 1'b0, 29'h18, 12'h800);
        $display("test disable done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        print_verdict;
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 0;
        t_mode;
        t_load;
        t_dis;
        print_verdict;
    end
endmodule
